/* File: design/adc_seq_pkg.sv */
// Package: timing, channel codes and result layout for the converter sequencer
package adc_seq_pkg;
	localparam int CLK_MHZ = 100;
	localparam int DATA_W = 8;
	localparam int RES_W = 9;
	localparam int PARITY_BIT = 8;
	localparam int SLOT_US = 8;
	localparam int SLOT_CYC = SLOT_US * CLK_MHZ;
	localparam int SLOTS_PER_SEQ = 4;
	localparam int SEQ_US = 32;
	// Delay after a dimming falling edge; 4 us typical, 3.6 to 4.9 allowed
	localparam int PHASE_DELAY_NS = 4000;
	localparam int PHASE_DELAY_CYC = (PHASE_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 10;
	localparam int INTERVAL_W = 9;
	localparam logic [RES_W-1:0] RESULT_RESET = 9'h100;
	localparam logic [2:0] CH_BOOST = 3'h0;
	localparam logic [2:0] CH_BATTERY = 3'h1;
	localparam logic [2:0] CH_TEMP = 3'h2;
	localparam logic [2:0] CH_LED1 = 3'h3;
	localparam logic [2:0] CH_LED2 = 3'h4;
	localparam int NUM_RES = 7;
	localparam logic [2:0] IDX_BOOST = 3'h0;
	localparam logic [2:0] IDX_BATTERY = 3'h1;
	localparam logic [2:0] IDX_TEMP = 3'h2;
	localparam logic [2:0] IDX_LED1_ON = 3'h3;
	localparam logic [2:0] IDX_LED1_STR = 3'h4;
	localparam logic [2:0] IDX_LED2_ON = 3'h5;
	localparam logic [2:0] IDX_LED2_STR = 3'h6;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_STORE = 2'b11
	} conv_state_t;
	// Odd parity: nine bits hold an odd count of ones
	function automatic logic [RES_W-1:0] with_parity(input logic [DATA_W-1:0] d);
		with_parity = {~(^d), d};
	endfunction
endpackage

/* File: design/result_bus_if.sv */
// Interface: write and read ports between the sequencer and the result store
`timescale 1ns/10ps
`default_nettype none
interface result_bus_if;
	logic we;
	logic [2:0] waddr;
	logic [8:0] wdata;
	logic [2:0] raddr;
	logic [8:0] rdata;
	modport writer (output we, output waddr, output wdata, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* File: design/result_store.sv */
// Result memory: seven parity-protected words, registered read
`timescale 1ns/10ps
`default_nettype none
module result_store (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Sequencer side
	result_bus_if.store bus
);
	import adc_seq_pkg::*;
	logic [RES_W-1:0] mem_q [NUM_RES];
	logic [RES_W-1:0] rdata_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NUM_RES; i++) begin
				mem_q[i] <= RESULT_RESET;
			end
		end else if (bus.we) begin
			mem_q[bus.waddr] <= bus.wdata;
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= RESULT_RESET;
		end else begin
			rdata_q <= mem_q[bus.raddr];
		end
	end
	assign bus.rdata = rdata_q;
endmodule // result_store
`default_nettype wire

/* File: design/sar_core.sv */
// Successive approximation engine: one trial bit per cycle
`timescale 1ns/10ps
`default_nettype none
module sar_core (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Control
	input wire logic start,
	output logic done,
	output logic [7:0] code,
	// Analog comparator
	output logic [7:0] dac_code,
	input wire logic comp_above
);
	import adc_seq_pkg::*;
	logic [DATA_W-1:0] trial_q, trial_d;
	logic [DATA_W-1:0] mask_q, mask_d;
	logic busy_q, done_q;
	logic [DATA_W-1:0] kept;
	assign kept = comp_above ? trial_q : (trial_q & ~mask_q);
	assign mask_d = busy_q ? (mask_q >> 1) : 8'h80;
	assign trial_d = start ? 8'h80 : (busy_q ? (kept | (mask_q >> 1)) : trial_q);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			trial_q <= 8'h00;
			mask_q <= 8'h80;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			trial_q <= trial_d;
			mask_q <= start ? 8'h80 : mask_d;
			busy_q <= start | (busy_q & (mask_q != 8'h01));
			done_q <= busy_q & (mask_q == 8'h01);
		end
	end
	assign dac_code = trial_q;
	assign code = trial_q;
	assign done = done_q;
endmodule // sar_core
`default_nettype wire

/* File: design/adc_sequencer.sv */
// Top: automatic converter sequencing, LED sampling requests and result readout
// What this block does
// - Every channel converts through an eight-bit successive approximation engine.
// - Internal sequencer picks mux input, converts and stores all channels unaided.
// - Host reads never disturb the sequence; they return the latest result.
// - Each conversion slot lasts eight microseconds.
// - Boost refreshed every 16 us; battery and temperature once per 32 us.
// - Non-zero forced interval allows LED samples at insertion points, periodic cadence.
// - Without forced operation a dimming falling edge raises that channel's request.
// - Request issued after a phase delay from the falling edge.
// - Input high updates on and string results; low updates string only.
// - One LED channel per request; a full sequence before the next.
// - Priority flag starts at channel 1 and after each service points to the channel not served.
// - Every result carries odd parity in bit eight.
// - Battery result code in bits 7:0, parity in bit 8.
// - Boost result stored with odd parity.
// - Temperature result also goes to thermal warning and shutdown logic.
// - Edge-to-action delay four microseconds typical.
// - LED results stored with odd parity in bit eight.
// - Constant dimming inputs still get forced periodic LED samples.
`timescale 1ns/10ps
`default_nettype none
module adc_sequencer (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Dimming inputs, pin or internal, and mode select
	input wire logic [1:0] channel_dim_input,
	input wire logic [1:0] internal_dim,
	input wire logic external_dimming,
	// Forced sampling interval in sequence periods
	input wire logic [adc_seq_pkg::INTERVAL_W-1:0] forced_sample_interval,
	// Analog front end
	output logic [2:0] mux_select,
	output logic [7:0] dac_code,
	input wire logic comp_above,
	// Register read port
	input wire logic [2:0] read_index,
	output logic [8:0] read_data,
	// Result views for other logic
	output logic [8:0] battery_supply,
	output logic [8:0] boost_rail,
	output logic [8:0] die_temperature,
	output logic [7:0] thermal_code
);
	import adc_seq_pkg::*;
	// ------------------------------------------------------------
	// Slot timing
	// ------------------------------------------------------------
	logic [CNT_W-1:0] slot_cnt_q;
	logic [1:0] slot_idx_q;
	logic slot_end;
	logic slot_is_led_q;
	logic [2:0] slot_ch_q;
	logic led_ch2_q;
	logic led_pin_high_q;
	conv_state_t state_q, state_d;
	assign slot_end = (slot_cnt_q == CNT_W'(SLOT_CYC - 1));
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			slot_cnt_q <= '0;
		end else begin
			slot_cnt_q <= slot_end ? '0 : slot_cnt_q + 1'b1;
		end
	end
	// ------------------------------------------------------------
	// Dimming edge detection and phase delay
	// ------------------------------------------------------------
	logic [1:0] dim_src;
	logic [1:0] dim_prev_q;
	logic [1:0] fall;
	logic [1:0] req_q;
	logic [CNT_W-1:0] delay_cnt_q [2];
	logic [1:0] delay_run_q;
	logic [1:0] delay_done;
	logic forced_mode;
	assign dim_src = external_dimming ? channel_dim_input : internal_dim;
	assign fall = dim_prev_q & ~dim_src;
	assign forced_mode = (forced_sample_interval != '0);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dim_prev_q <= 2'b00;
		end else begin
			dim_prev_q <= dim_src;
		end
	end
	genvar g;
	for (g = 0; g < 2; g++) begin : g_delay
		assign delay_done[g] = delay_run_q[g] &&
			(delay_cnt_q[g] == CNT_W'(PHASE_DELAY_CYC - 1));
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				delay_run_q[g] <= 1'b0;
				delay_cnt_q[g] <= '0;
			end else if (fall[g]) begin
				delay_run_q[g] <= 1'b1;
				delay_cnt_q[g] <= '0;
			end else if (delay_done[g]) begin
				delay_run_q[g] <= 1'b0;
			end else if (delay_run_q[g]) begin
				delay_cnt_q[g] <= delay_cnt_q[g] + 1'b1;
			end
		end
	end
	// ------------------------------------------------------------
	// Forced request cadence in whole sequences
	// ------------------------------------------------------------
	logic seq_end;
	logic [INTERVAL_W-1:0] seq_cnt_q;
	logic forced_tick;
	assign seq_end = slot_end && !slot_is_led_q && (slot_idx_q == 2'(SLOTS_PER_SEQ - 1));
	assign forced_tick = forced_mode && seq_end && (seq_cnt_q >= forced_sample_interval - 1'b1);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seq_cnt_q <= '0;
		end else if (!forced_mode || forced_tick) begin
			seq_cnt_q <= '0;
		end else if (seq_end) begin
			seq_cnt_q <= seq_cnt_q + 1'b1;
		end
	end
	// ------------------------------------------------------------
	// Request arbitration and lockout
	// ------------------------------------------------------------
	logic prio_ch2_q;
	logic lock_q;
	logic [2:0] lock_slots_q;
	logic grant;
	logic grant_ch2;
	logic led_insert_point;
	// Edges still count in forced mode; the forced tick sets both requests and wins over a grant clear in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			req_q <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (delay_done[i] || forced_tick) begin
					req_q[i] <= 1'b1;
				end else if (grant && (grant_ch2 == i[0])) begin
					req_q[i] <= 1'b0;
				end
			end
		end
	end
	assign led_insert_point = slot_end && !slot_is_led_q;
	assign grant = led_insert_point && !lock_q && (req_q != 2'b00);
	assign grant_ch2 = (req_q == 2'b11) ? prio_ch2_q : req_q[1];
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prio_ch2_q <= 1'b0;
			lock_q <= 1'b0;
			lock_slots_q <= '0;
		end else if (grant) begin
			prio_ch2_q <= ~grant_ch2;
			lock_q <= 1'b1;
			lock_slots_q <= '0;
		end else if (led_insert_point && lock_q) begin
			lock_slots_q <= lock_slots_q + 1'b1;
			if (lock_slots_q == 3'(SLOTS_PER_SEQ - 1)) begin
				lock_q <= 1'b0;
			end
		end
	end
	// ------------------------------------------------------------
	// Slot scheduling
	// ------------------------------------------------------------
	logic [2:0] main_ch;
	logic [1:0] next_idx;
	assign next_idx = slot_is_led_q ? slot_idx_q : slot_idx_q + 1'b1;
	assign main_ch = next_idx[0] ? (next_idx[1] ? CH_TEMP : CH_BATTERY) : CH_BOOST;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			slot_idx_q <= '0;
			slot_is_led_q <= 1'b0;
			slot_ch_q <= CH_BOOST;
			led_ch2_q <= 1'b0;
		end else if (slot_end) begin
			slot_is_led_q <= grant;
			// Index holds across an LED slot, so the main order resumes
			slot_idx_q <= next_idx;
			slot_ch_q <= grant ? (grant_ch2 ? CH_LED2 : CH_LED1) : main_ch;
			led_ch2_q <= grant ? grant_ch2 : led_ch2_q;
		end
	end
	// ------------------------------------------------------------
	// Conversion control
	// ------------------------------------------------------------
	logic sar_start;
	logic sar_done;
	logic [7:0] sar_code;
	logic [7:0] dac_d;
	assign sar_start = (state_q == ST_IDLE) && (slot_cnt_q == CNT_W'(1));
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (sar_start) begin
					state_d = ST_CONV;
				end
			end
			ST_CONV: begin
				if (sar_done) begin
					state_d = ST_STORE;
				end
			end
			ST_STORE: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_IDLE;
			led_pin_high_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (sar_start) begin
				led_pin_high_q <= led_ch2_q ? channel_dim_input[1] : channel_dim_input[0];
			end
		end
	end
	sar_core u_sar (
		.clk(clk),
		.arst_n(arst_n),
		.start(sar_start),
		.done(sar_done),
		.code(sar_code),
		.dac_code(dac_d),
		.comp_above(comp_above)
	);
	// ------------------------------------------------------------
	// Result storage and readout
	// ------------------------------------------------------------
	result_bus_if rbus ();
	logic [RES_W-1:0] new_word;
	logic store_now;
	logic second_q;
	logic [2:0] str_idx;
	logic [2:0] on_idx;
	assign store_now = (state_q == ST_STORE);
	assign new_word = with_parity(sar_code);
	assign str_idx = led_ch2_q ? IDX_LED2_STR : IDX_LED1_STR;
	assign on_idx = led_ch2_q ? IDX_LED2_ON : IDX_LED1_ON;
	// LED slot with pin high writes on-voltage, then string next cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			second_q <= 1'b0;
		end else begin
			second_q <= store_now && slot_is_led_q && led_pin_high_q;
		end
	end
	logic [RES_W-1:0] word_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			word_q <= RESULT_RESET;
		end else if (store_now) begin
			word_q <= new_word;
		end
	end
	assign rbus.we = store_now | second_q;
	assign rbus.wdata = second_q ? word_q : new_word;
	assign rbus.waddr = second_q ? str_idx :
		!slot_is_led_q ? slot_ch_q :
		led_pin_high_q ? on_idx : str_idx;
	assign rbus.raddr = read_index;
	result_store u_store (
		.clk(clk),
		.arst_n(arst_n),
		.bus(rbus)
	);
	// Local copies so side outputs need no extra memory read port
	logic [RES_W-1:0] bat_q, bst_q, tmp_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bat_q <= RESULT_RESET;
			bst_q <= RESULT_RESET;
			tmp_q <= RESULT_RESET;
		end else if (store_now && !slot_is_led_q) begin
			if (slot_ch_q == CH_BATTERY) bat_q <= new_word;
			if (slot_ch_q == CH_BOOST) bst_q <= new_word;
			if (slot_ch_q == CH_TEMP) tmp_q <= new_word;
		end
	end
	logic [2:0] mux_q;
	logic [7:0] dac_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mux_q <= CH_BOOST;
			dac_q <= 8'h00;
		end else begin
			mux_q <= slot_ch_q;
			dac_q <= dac_d;
		end
	end
	assign mux_select = mux_q;
	assign dac_code = dac_q;
	assign read_data = rbus.rdata;
	assign battery_supply = bat_q;
	assign boost_rail = bst_q;
	assign die_temperature = tmp_q;
	assign thermal_code = tmp_q[7:0];
endmodule // adc_sequencer
`default_nettype wire

/* File: tb/adc_sequencer_props.sv */
// Checker: slot timing, slot order and result parity of the sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_sequencer_props
	import adc_seq_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Watched outputs
	input wire logic [2:0] mux_select,
	input wire logic [8:0] read_data,
	input wire logic [8:0] battery_supply,
	input wire logic [8:0] boost_rail,
	input wire logic [8:0] die_temperature,
	input wire logic [7:0] thermal_code
);
	logic [2:0] mux_prev_q;
	logic [12:0] slot_cnt_q;
	logic [12:0] led_cnt_q;
	logic seen_q;
	logic led_seen_q;
	wire logic chg = mux_select != mux_prev_q;
	wire logic led_in = chg && (mux_select >= CH_LED1);
	// Led counter saturates so a long quiet stretch cannot wrap it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mux_prev_q <= CH_BOOST;
			slot_cnt_q <= '0;
			led_cnt_q <= '0;
			seen_q <= 1'b0;
			led_seen_q <= 1'b0;
		end else begin
			mux_prev_q <= mux_select;
			slot_cnt_q <= chg ? 13'h0000 : slot_cnt_q + 13'h0001;
			led_cnt_q <= led_in ? 13'h0000 : led_cnt_q + {12'h000, ~&led_cnt_q};
			seen_q <= seen_q | chg;
			led_seen_q <= led_seen_q | led_in;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// ----
	// Assertions
	// ----
	a_read_parity: assert property ($past(arst_n) |-> ^read_data)
		else $error("read data parity even");
	a_battery_parity: assert property (^battery_supply)
		else $error("battery parity even");
	a_boost_parity: assert property (^boost_rail)
		else $error("boost parity even");
	a_temp_parity: assert property (^die_temperature)
		else $error("temperature parity even");
	a_thermal_copy: assert property ($stable(die_temperature) ##1 $stable(die_temperature)
		|-> thermal_code == die_temperature[7:0]) else $error("thermal code differs");
	a_mux_legal: assert property (mux_select <= CH_LED2)
		else $error("mux code out of range");
	a_slot_length: assert property (chg && seen_q |-> slot_cnt_q == SLOT_CYC - 1)
		else $error("slot length wrong");
	a_main_order: assert property (chg && (mux_select == CH_BATTERY || mux_select == CH_TEMP)
		|-> mux_prev_q != CH_BATTERY && mux_prev_q != CH_TEMP) else $error("slot order wrong");
	a_led_spacing: assert property (led_in && led_seen_q
		|-> led_cnt_q >= SLOTS_PER_SEQ * SLOT_CYC) else $error("led slots too close");
	a_boost_slot: assert property ($changed(boost_rail) |-> mux_select == CH_BOOST)
		else $error("boost changed outside its slot");
	a_battery_slot: assert property ($changed(battery_supply) |-> mux_select == CH_BATTERY)
		else $error("battery changed outside its slot");
	a_temp_slot: assert property ($changed(die_temperature) |-> mux_select == CH_TEMP)
		else $error("temperature changed outside its slot");
endmodule // adc_sequencer_props
bind adc_sequencer adc_sequencer_props i_props (
	.clk(clk),
	.arst_n(arst_n),
	.mux_select(mux_select),
	.read_data(read_data),
	.battery_supply(battery_supply),
	.boost_rail(boost_rail),
	.die_temperature(die_temperature),
	.thermal_code(thermal_code)
);
`default_nettype wire

/* File: tb/afe_model.sv */
// Front end model: comparator answer per selected channel
`timescale 1ns/10ps
`default_nettype none
module afe_model (
	// Converter side
	input wire logic [2:0] mux_select,
	input wire logic [7:0] dac_code,
	output logic comp_above,
	// Input level per channel, 1 = full scale
	input wire logic [4:0] level
);
	// Only the extremes: mid values would hinge on the comparator lag
	assign comp_above = (mux_select <= 3'h4) ? level[mux_select] : 1'b0;
endmodule // afe_model
`default_nettype wire

/* File: tb/tb_adc_sequencer.sv */
// Testbench: sequencer scenarios against a front end model
`timescale 1ns/10ps
`default_nettype none
module tb_adc_sequencer;
	import adc_seq_pkg::*;
	localparam logic [8:0] FULL = 9'h1ff;
	localparam logic [8:0] EMPTY = 9'h100;
	logic clk;
	logic arst_n;
	logic [1:0] channel_dim_input;
	logic [1:0] internal_dim;
	logic external_dimming;
	logic [INTERVAL_W-1:0] forced_sample_interval;
	logic [2:0] mux_select;
	logic [7:0] dac_code;
	logic comp_above;
	logic [2:0] read_index;
	logic [8:0] read_data;
	logic [8:0] battery_supply;
	logic [8:0] boost_rail;
	logic [8:0] die_temperature;
	logic [7:0] thermal_code;
	logic [4:0] level;
	int num_errors;
	int comparisons;
	int cycles;
	adc_sequencer i_dut (
		.clk(clk),
		.arst_n(arst_n),
		.channel_dim_input(channel_dim_input),
		.internal_dim(internal_dim),
		.external_dimming(external_dimming),
		.forced_sample_interval(forced_sample_interval),
		.mux_select(mux_select),
		.dac_code(dac_code),
		.comp_above(comp_above),
		.read_index(read_index),
		.read_data(read_data),
		.battery_supply(battery_supply),
		.boost_rail(boost_rail),
		.die_temperature(die_temperature),
		.thermal_code(thermal_code)
	);
	afe_model i_afe (
		.mux_select(mux_select),
		.dac_code(dac_code),
		.comp_above(comp_above),
		.level(level)
	);
	// ----
	// Helpers
	// ----
	task check(input logic [8:0] got, input logic [8:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task rd(input logic [2:0] idx, input logic [8:0] exp, input string what);
		@(negedge clk) read_index = idx;
		@(negedge clk) check(read_data, exp, what);
	endtask
	// Reads back to back while waiting, so host traffic overlaps slots
	task poll(input logic [2:0] idx, input logic [8:0] exp, input int lim, input string what);
		int n;
		n = 0;
		read_index = idx;
		do begin
			@(negedge clk);
			n++;
		end while (read_data !== exp && n < lim);
		check(read_data, exp, what);
	endtask
	task final_report;
		$display("num_errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ----
	// Scenarios
	// ----
	task t_reset;
		check(boost_rail, EMPTY, "boost reset");
		for (int i = 1; i < NUM_RES; i++) begin
			rd(3'(i), EMPTY, "reset value");
		end
	endtask
	task t_main;
		repeat (3300) @(negedge clk);
		rd(IDX_BOOST, FULL, "boost");
		rd(IDX_BATTERY, FULL, "battery");
		rd(IDX_TEMP, FULL, "temperature");
		check(battery_supply, FULL, "battery view");
		check({1'b0, thermal_code}, 9'h0ff, "thermal");
		check({1'b0, dac_code}, 9'h0ff, "dac code");
		check({1'b0, thermal_code - 8'h14}, 9'h0eb, "celsius");
		rd(IDX_LED1_STR, EMPTY, "no led request");
	endtask
	task t_refresh;
		level[CH_BOOST] = 1'b0;
		level[CH_BATTERY] = 1'b0;
		repeat (1650) @(negedge clk);
		check(boost_rail, EMPTY, "boost refresh");
		repeat (1650) @(negedge clk);
		check(battery_supply, EMPTY, "battery refresh");
	endtask
	task t_edge_delay;
		channel_dim_input[0] = 1'b0;
		repeat (390) @(negedge clk);
		rd(IDX_LED1_STR, EMPTY, "before phase delay");
		poll(IDX_LED1_STR, FULL, 2500, "led1 string");
		rd(IDX_LED1_ON, EMPTY, "led1 on with pin low");
		rd(IDX_LED2_STR, EMPTY, "led2 untouched");
	endtask
	task t_priority;
		channel_dim_input = 2'b11;
		repeat (10) @(negedge clk);
		channel_dim_input = 2'b00;
		repeat (100) @(negedge clk);
		channel_dim_input = 2'b11;
		poll(IDX_LED2_ON, FULL, 6000, "led2 first");
		rd(IDX_LED1_ON, EMPTY, "led1 waits");
		poll(IDX_LED1_ON, FULL, 5000, "led1 later");
	endtask
	task t_internal;
		external_dimming = 1'b0;
		level[CH_LED1] = 1'b0;
		internal_dim = 2'b10;
		poll(IDX_LED1_STR, EMPTY, 6000, "internal edge");
		rd(IDX_LED1_ON, EMPTY, "on with pin high");
	endtask
	task t_forced;
		level[CH_LED1] = 1'b1;
		level[CH_LED2] = 1'b0;
		forced_sample_interval = 9'h001;
		poll(IDX_LED2_STR, EMPTY, 9000, "forced led2");
		poll(IDX_LED1_STR, FULL, 9000, "forced led1");
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Run needs about 31200 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			num_errors++;
			$display("unexpected at %0t: timeout", $time);
			final_report();
		end
	end
	initial begin
		arst_n = 1'b0;
		channel_dim_input = 2'b11;
		internal_dim = 2'b11;
		external_dimming = 1'b1;
		forced_sample_interval = '0;
		read_index = '0;
		level = 5'h1f;
		num_errors = 0;
		comparisons = 0;
		repeat (8) @(negedge clk);
		arst_n = 1'b1;
		t_reset();
		t_main();
		t_refresh();
		t_edge_delay();
		t_priority();
		t_internal();
		t_forced();
		final_report();
	end
endmodule // tb_adc_sequencer
`default_nettype wire
